// ---- hw/bridge_cfg_header_tail.sv ----
`timescale 1ns/1ps
module bridge_cfg_header_tail #(
  parameter int LONG_CYCLES = bridge_cfg_pkg::DT_LONG_CYCLES,
  parameter int SHORT_CYCLES = bridge_cfg_pkg::DT_SHORT_CYCLES,
  parameter bit AER_SUPPORTED = 1'b1
) (
  input wire logic clock,
  input wire logic rst,
  input wire bridge_cfg_pkg::cfg_req_t cfg_req,
  output logic [31:0] cfg_rdata,
  output logic cfg_rvalid,
  input wire logic conventional_mode,
  input wire logic aer_dt_mask,
  input wire logic aer_dt_fatal,
  input wire logic dt_start,
  input wire logic dt_repeat,
  input wire logic sec_int_req,
  output logic pri_int_req,
  output logic dt_discard,
  output bridge_cfg_pkg::err_msg_t err_msg,
  input wire logic [31:0] io_addr,
  input wire logic [15:0] io_lower_top,
  output logic io_below_top
);
  // Counter width and limit order are fixed at elaboration
  if (LONG_CYCLES < 2 || SHORT_CYCLES < 2 || SHORT_CYCLES > LONG_CYCLES) begin : g_bad_counts
    $error("Discard timer counts out of range");
  end

  localparam int CW = $clog2(LONG_CYCLES + 1);
  localparam logic [5:0] WORD_IO = bridge_cfg_pkg::OFF_IO_TOP_UPPER[7:2];
  localparam logic [5:0] WORD_CAP = bridge_cfg_pkg::OFF_CAP_PTR[7:2];
  localparam logic [5:0] WORD_LINE = bridge_cfg_pkg::OFF_INT_LINE[7:2];
  localparam logic [5:0] WORD_CTL = bridge_cfg_pkg::OFF_BRIDGE_CTL[7:2];
  localparam int FLAG_BIT = bridge_cfg_pkg::BIT_DT_FLAG;
  localparam int EN_BIT = bridge_cfg_pkg::BIT_DT_MSG_EN;
  localparam int SEL_BIT = bridge_cfg_pkg::BIT_DT_SELECT;
  localparam logic [15:0] CTL_RESET = bridge_cfg_pkg::RST_BRIDGE_CTL;

  logic [15:0] io_range_top_upper_field_ff;
  logic [7:0] int_line_ff;
  logic [7:0] ctl_low_ff;
  logic discard_timeout_select_ff;
  logic discard_timeout_msg_enable_ff;
  logic discard_timeout_flag_ff;
  logic [CW-1:0] dt_cnt_ff;
  logic dt_run_ff;
  logic [31:0] rdata_ff;
  logic rvalid_ff;
  logic discard_ff;
  logic err_fatal_ff;
  logic err_nonfatal_ff;
  logic int_fwd_ff;
  logic below_ff;

  logic wr;
  logic rd;
  logic [5:0] word;
  logic [31:0] dw;
  logic [3:0] be;
  logic hit_io;
  logic hit_line;
  logic hit_ctl;
  logic flag_clear;
  logic [15:0] ctl_word;
  logic [31:0] io_top_full;
  logic [CW-1:0] dt_limit;
  logic expire;
  logic msg_go;
  logic sev_fatal;
  logic [31:0] io_word;
  logic [31:0] cap_word;
  logic [31:0] line_word;
  logic [31:0] rd_word;

  // One access per cycle, decoded on the dword index
  assign wr = cfg_req.valid && cfg_req.write;
  assign rd = cfg_req.valid && !cfg_req.write;
  assign word = cfg_req.addr[7:2];
  assign be = cfg_req.byte_en;
  assign dw = cfg_req.wdata;
  assign hit_io = wr && word == WORD_IO;
  assign hit_line = wr && word == WORD_LINE;
  assign hit_ctl = wr && word == WORD_CTL;

  // Io top upper sits in bytes 2 and 3 of its dword
  always_ff @(posedge clock) begin
    if (rst) begin
      io_range_top_upper_field_ff <= bridge_cfg_pkg::RST_IO_TOP_UPPER;
    end else if (hit_io) begin
      if (be[2]) begin
        io_range_top_upper_field_ff[7:0] <= dw[23:16];
      end
      if (be[3]) begin
        io_range_top_upper_field_ff[15:8] <= dw[31:24];
      end
    end
  end

  // Scratchpad only, nothing reads it internally
  always_ff @(posedge clock) begin
    if (rst) begin
      int_line_ff <= bridge_cfg_pkg::RST_INT_LINE;
    end else if (hit_line && be[0]) begin
      int_line_ff <= dw[7:0];
    end
  end

  // Low control byte is plain storage here
  always_ff @(posedge clock) begin
    if (rst) begin
      ctl_low_ff <= CTL_RESET[7:0];
    end else if (hit_ctl && be[2]) begin
      ctl_low_ff <= dw[23:16] & bridge_cfg_pkg::CTL_RW_MASK[7:0];
    end
  end

  // Timeout select changes the limit at once, even while the timer is running
  always_ff @(posedge clock) begin
    if (rst) begin
      discard_timeout_select_ff <= CTL_RESET[SEL_BIT];
    end else if (hit_ctl && be[3]) begin
      discard_timeout_select_ff <= dw[16 + SEL_BIT];
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      discard_timeout_msg_enable_ff <= CTL_RESET[EN_BIT];
    end else if (hit_ctl && be[3]) begin
      discard_timeout_msg_enable_ff <= dw[16 + EN_BIT];
    end
  end

  assign flag_clear = hit_ctl && be[3] && dw[16 + FLAG_BIT];

  // Set beats a same-cycle clear so no expiry is lost
  always_ff @(posedge clock) begin
    if (rst) begin
      discard_timeout_flag_ff <= CTL_RESET[FLAG_BIT];
    end else if (expire) begin
      discard_timeout_flag_ff <= 1'b1;
    end else if (flag_clear) begin
      discard_timeout_flag_ff <= 1'b0;
    end
  end

  // Reserved nibble and the primary timer bit are hardwired low
  assign ctl_word = {
    bridge_cfg_pkg::CTL_RSVD_VAL,
    discard_timeout_msg_enable_ff,
    discard_timeout_flag_ff,
    discard_timeout_select_ff,
    1'b0,
    ctl_low_ff
  };

  assign dt_limit = discard_timeout_select_ff ?
    CW'(SHORT_CYCLES - 1) : CW'(LONG_CYCLES - 1);
  assign expire = dt_run_ff && !dt_repeat && dt_cnt_ff == dt_limit;

  // Timer runs from completion at queue head until repeat or expiry
  always_ff @(posedge clock) begin
    if (rst) begin
      dt_run_ff <= 1'b0;
    end else if (dt_repeat || expire) begin
      dt_run_ff <= 1'b0;
    end else if (dt_start) begin
      dt_run_ff <= 1'b1;
    end
  end

  // Count restarts from zero on every start from idle; a start during a run does not restart it
  always_ff @(posedge clock) begin
    if (rst || dt_repeat || expire || !dt_run_ff) begin
      dt_cnt_ff <= '0;
    end else begin
      dt_cnt_ff <= dt_cnt_ff + CW'(1);
    end
  end

  // Enable only counts in conventional mode; AER unmasked still reports
  assign msg_go = (conventional_mode && discard_timeout_msg_enable_ff)
    || (AER_SUPPORTED && !aer_dt_mask);
  assign sev_fatal = AER_SUPPORTED && aer_dt_fatal;

  always_ff @(posedge clock) begin
    if (rst) begin
      discard_ff <= 1'b0;
    end else begin
      discard_ff <= expire;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      err_fatal_ff <= 1'b0;
    end else begin
      err_fatal_ff <= expire && msg_go && sev_fatal;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      err_nonfatal_ff <= 1'b0;
    end else begin
      err_nonfatal_ff <= expire && msg_go && !sev_fatal;
    end
  end

  // Secondary interrupts pass through regardless of pin value zero
  always_ff @(posedge clock) begin
    if (rst) begin
      int_fwd_ff <= 1'b0;
    end else begin
      int_fwd_ff <= sec_int_req;
    end
  end

  // Only field bits 11:0 count, as address bits 31:20
  assign io_top_full = {io_range_top_upper_field_ff[11:0], bridge_cfg_pkg::IO_TOP_LOW_ONES};

  always_ff @(posedge clock) begin
    if (rst) begin
      below_ff <= 1'b0;
    end else begin
      below_ff <= io_addr <= io_top_full;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      rvalid_ff <= 1'b0;
    end else begin
      rvalid_ff <= rd;
    end
  end

  assign io_word = {io_range_top_upper_field_ff, io_lower_top};
  assign cap_word = {24'h000000, bridge_cfg_pkg::VAL_CAP_PTR};
  assign line_word = {ctl_word, bridge_cfg_pkg::VAL_INT_PIN, int_line_ff};

  // Unmapped words read zero
  always_comb begin
    rd_word = 32'h00000000;
    case (word)
      WORD_IO: begin
        rd_word = io_word;
      end
      WORD_CAP: begin
        rd_word = cap_word;
      end
      WORD_LINE: begin
        rd_word = line_word;
      end
      default: begin
        rd_word = 32'h00000000;
      end
    endcase
  end

  // Sampled every cycle; only meaningful with the valid pulse
  always_ff @(posedge clock) begin
    if (rst) begin
      rdata_ff <= '0;
    end else begin
      rdata_ff <= rd_word;
    end
  end

  assign cfg_rdata = rdata_ff;
  assign cfg_rvalid = rvalid_ff;
  assign pri_int_req = int_fwd_ff;
  assign dt_discard = discard_ff;
  assign err_msg = '{nonfatal: err_nonfatal_ff, fatal: err_fatal_ff};
  assign io_below_top = below_ff;
endmodule

// ---- hw/bridge_cfg_pkg.sv ----
package bridge_cfg_pkg;
  localparam logic [7:0] OFF_IO_TOP_UPPER = 8'h32;
  localparam logic [7:0] OFF_CAP_PTR = 8'h34;
  localparam logic [7:0] OFF_INT_LINE = 8'h3c;
  localparam logic [7:0] OFF_INT_PIN = 8'h3d;
  localparam logic [7:0] OFF_BRIDGE_CTL = 8'h3e;
  localparam logic [15:0] RST_IO_TOP_UPPER = 16'h0000;
  localparam logic [7:0] VAL_CAP_PTR = 8'h50;
  localparam logic [7:0] RST_INT_LINE = 8'hff;
  localparam logic [7:0] VAL_INT_PIN = 8'h00;
  localparam logic [15:0] RST_BRIDGE_CTL = 16'h0000;
  localparam logic [19:0] IO_TOP_LOW_ONES = 20'hfffff;
  localparam int BIT_DT_MSG_EN = 11;
  localparam int BIT_DT_FLAG = 10;
  localparam int BIT_DT_SELECT = 9;
  localparam logic [15:0] CTL_RW_MASK = 16'h0bff;
  localparam logic [3:0] CTL_RSVD_VAL = 4'h0;
  localparam int DT_LONG_CYCLES = 32768;
  localparam int DT_SHORT_CYCLES = 1024;

  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
    logic [3:0] byte_en;
    logic [31:0] wdata;
  } cfg_req_t;

  typedef struct packed {
    logic nonfatal;
    logic fatal;
  } err_msg_t;
endpackage

// ---- tb/cfg_host_model.sv ----
`timescale 1ns/1ps
module cfg_host_model (
  input wire logic clock,
  input wire logic [31:0] cfg_rdata,
  input wire logic cfg_rvalid,
  output bridge_cfg_pkg::cfg_req_t cfg_req
);
  initial cfg_req = '0;
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] r);
    @(negedge clock);
    cfg_req = {1'b1, w, a, 4'hf, d};
    @(negedge clock);
    cfg_req = '0;
    r = cfg_rvalid ? cfg_rdata : 32'h0bad_0bad;
  endtask
endmodule

// ---- tb/bridge_cfg_chk.sv ----
`timescale 1ns/1ps
module bridge_cfg_chk (
  input wire logic clock,
  input wire logic rst,
  input wire bridge_cfg_pkg::cfg_req_t cfg_req,
  input wire logic [31:0] cfg_rdata,
  input wire logic cfg_rvalid,
  input wire logic sec_int_req,
  input wire logic pri_int_req,
  input wire logic dt_discard,
  input wire bridge_cfg_pkg::err_msg_t err_msg
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  wire rd = cfg_req.valid && !cfg_req.write;
  wire w3c = rd && cfg_req.addr[7:2] == 6'h0f;
  property p_ans; !$past(rst) |-> cfg_rvalid == $past(rd); endproperty
  a_ans: assert property (p_ans) else $error("bad answer");
  property p_cap; rd && cfg_req.addr[7:2] == 6'h0d |=> cfg_rdata == 32'h50; endproperty
  a_cap: assert property (p_cap) else $error("bad pointer");
  property p_pin; w3c |=> cfg_rdata[15:8] == 8'h00; endproperty
  a_pin: assert property (p_pin) else $error("bad pin");
  property p_rsv; w3c |=> cfg_rdata[31:28] == 4'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("bad reserved");
  property p_fwd; !$past(rst) |-> pri_int_req == $past(sec_int_req); endproperty
  a_fwd: assert property (p_fwd) else $error("no forward");
  property p_msg; err_msg.nonfatal || err_msg.fatal |-> dt_discard; endproperty
  a_msg: assert property (p_msg) else $error("stray message");
  property p_sev; !(err_msg.nonfatal && err_msg.fatal); endproperty
  a_sev: assert property (p_sev) else $error("two severities");
  property p_one; dt_discard |=> !dt_discard; endproperty
  a_one: assert property (p_one) else $error("long discard");
endmodule
bind bridge_cfg_header_tail bridge_cfg_chk bridge_cfg_chk_i (.clock(clock), .rst(rst),
  .cfg_req(cfg_req), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
  .sec_int_req(sec_int_req), .pri_int_req(pri_int_req), .dt_discard(dt_discard),
  .err_msg(err_msg));

// ---- tb/bridge_cfg_header_tail_test.sv ----
`timescale 1ns/1ps
module bridge_cfg_header_tail_test;
  logic clock = 0;
  logic rst = 1;
  logic dts = 0;
  logic sec = 0;
  logic conv = 1;
  logic mask = 1;
  logic fsel = 0;
  logic go;
  logic pri, disc, below, rv;
  logic [31:0] ia = 0;
  logic [15:0] lower = 0;
  logic [31:0] r, d, lim, rdat;
  logic [15:0] ctl;
  logic [1:0] exp_q[$];
  int fails = 0, check_count = 0, cyc = 0, n, cycles;
  int m_top = 0, m_line = 255, m_ctl = 0;
  bridge_cfg_pkg::cfg_req_t req;
  bridge_cfg_pkg::err_msg_t em;
  initial forever #12.5 clock = ~clock;
  always @(posedge clock) if (++cyc == 3000) begin
    fails++;
    end_of_test();
  end
  cfg_host_model cfg_host_model_i (.clock(clock), .cfg_rdata(rdat), .cfg_rvalid(rv),
    .cfg_req(req));
  // Short timer counts keep the run brief
  bridge_cfg_header_tail #(.LONG_CYCLES(64), .SHORT_CYCLES(16)) bridge_cfg_header_tail_i (
    .clock(clock), .rst(rst), .cfg_req(req), .cfg_rdata(rdat), .cfg_rvalid(rv),
    .conventional_mode(conv), .aer_dt_mask(mask), .aer_dt_fatal(fsel), .dt_start(dts),
    .dt_repeat(1'b0), .sec_int_req(sec), .pri_int_req(pri), .dt_discard(disc),
    .err_msg(em), .io_addr(ia), .io_lower_top(lower), .io_below_top(below));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Register model kept from the rules alone
  function automatic logic [31:0] model_word(input logic [7:0] a);
    case (a[7:2])
      6'h0c: return {m_top[15:0], lower};
      6'h0d: return 32'h00000050;
      6'h0f: return {m_ctl[15:0], 8'h00, m_line[7:0]};
      default: return 32'h00000000;
    endcase
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    cfg_host_model_i.acc(1'b1, a, v, r);
    if (a[7:2] == 6'h0c) m_top = v[31:16];
    if (a[7:2] == 6'h0f) begin
      m_line = v[7:0];
      m_ctl = (m_ctl & 32'h00000400) | (v[31:16] & 32'h00000aff);
      if (v[26]) m_ctl = m_ctl & ~32'h00000400;
    end
  endtask
  task automatic rd(input logic [7:0] a);
    cfg_host_model_i.acc(1'b0, a, 32'h0, r);
    chk(r, model_word(a));
  endtask
  task automatic end_of_test;
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    void'($urandom(91234));
    repeat (5) @(negedge clock);
    rst = 0;
    rd(8'h30);
    rd(8'h34);
    rd(8'h3c);
    rd(8'h38);
    $display("reset test done");
    repeat (4) begin
      d = $urandom;
      lower = $urandom;
      wr(8'h30, d);
      wr(8'h34, ~d);
      wr(8'h3c, d);
      rd(8'h30);
      rd(8'h34);
      rd(8'h3c);
      lim = {d[27:16], 20'hfffff};
      for (n = 0; n < 2; n++) begin
        ia = lim + n;
        repeat (2) @(negedge clock);
        chk(below, ia <= lim);
      end
    end
    $display("register test done");
    for (int e = 0; e < 5; e++) begin
      conv = e != 4;
      mask = e != 3;
      fsel = e == 2;
      ctl = {4'h0, e == 1 || e == 2 || e == 4, 1'b0, e != 0, 9'h000};
      wr(8'h3c, {ctl, 16'h005a});
      cycles = e != 0 ? 16 : 64;
      go = (conv && ctl[11]) || !mask;
      exp_q.push_back({go && !fsel, go && fsel});
      dts = 1;
      @(negedge clock);
      dts = 0;
      for (n = 0; !disc && n < 100; n++) @(negedge clock);
      chk(n, cycles);
      chk(em, exp_q.pop_front());
      m_ctl = m_ctl | 32'h00000400;
      rd(8'h3c);
      wr(8'h3c, {ctl, 16'h005a});
      rd(8'h3c);
      wr(8'h3c, {ctl | 16'h0400, 16'h005a});
      rd(8'h3c);
    end
    $display("timer test done");
    sec = 1;
    @(negedge clock);
    chk(pri, 1);
    sec = 0;
    @(negedge clock);
    chk(pri, 0);
    $display("forward test done");
    end_of_test();
  end
endmodule
